//--- shared/i2c_ctl_consts.svh
`ifndef I2C_CTL_CONSTS_SVH
`define I2C_CTL_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 9'h000
`define OFS_TAR 9'h004
`define OFS_SAR 9'h008
`define OFS_DATA 9'h00c
`define OFS_HCNT 9'h010
`define OFS_LCNT 9'h014
`define OFS_HOLD 9'h018
`define OFS_STAT 9'h01c
`define OFS_CMD_RD 9'h020
`define OFS_SEL 9'h100
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_EN 0
`define CTRL_MST 1
`define CTRL_RSTA 2
`define CTRL_A10 3
`define ST_GCALL 10
`define ST_ARB 11
`define ST_NACK 12
`define ST_HS 13
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define RST_CTRL 4'h0
`define RST_HCNT 16'h04e2
`define RST_LCNT 16'h04e2
`define RST_HOLD 16'h004b
`define FIFO_DEPTH 4'h8
// ----------------------------------------
// first byte patterns
// ----------------------------------------
`define A10_MARK 5'h1e
`define HS_MARK 5'h01
`define RSV_TOP 5'h1f
`define RSV_A 7'h08
`define RSV_B 7'h0c
`define RSV_C 7'h61
`endif

//--- shared/i2c_ctl_pkg.sv
`default_nettype none
package i2c_ctl_pkg;
  // master sequencer states
  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_START = 3'h1, M_LOW = 3'h3,
    M_HIGH = 3'h2, M_STOP = 3'h6, M_RSTART = 3'h7
  } mst_t;
  // slave states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_ADDR2 = 3'h3,
    S_RX = 3'h2, S_TX = 3'h6
  } slv_t;
  // kind of byte on the wire in master mode
  typedef enum logic [1:0] {
    K_ADDR1 = 2'h0, K_ADDR2 = 2'h1, K_WR = 2'h3, K_RD = 2'h2
  } kind_t;
endpackage : i2c_ctl_pkg
`default_nettype wire

//--- core/i2c_fifo_ctl.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ctl_consts.svh"

module ctl_fifo #(parameter int W = 8) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic push,
  input wire logic [W-1:0] din,
  // drain side
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic [3:0] level
);
  logic [W-1:0] mem_r [0:7];
  logic [2:0] wp_r;
  logic [2:0] rp_r;
  logic [3:0] cnt_r;
  wire do_push = push && (cnt_r != `FIFO_DEPTH);
  wire do_pop = pop && (cnt_r != 4'h0);
  assign dout = mem_r[rp_r];
  assign level = cnt_r;
  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (do_push) mem_r[wp_r] <= din;
  end
  // pointers and level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= 3'h0;
      rp_r <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      wp_r <= wp_r + {2'h0, do_push};
      rp_r <= rp_r + {2'h0, do_pop};
      cnt_r <= cnt_r + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule : ctl_fifo

module i2c_fifo_ctl (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic [8:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // bus clock pin
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  // bus data pin
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  // route to this controller
  output logic CTL_SELECT
);
  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  logic [1:0] scl_q_r;
  logic [1:0] sda_q_r;
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      scl_q_r <= 2'h3;
      sda_q_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_q_r <= {scl_q_r[0], SCL_I};
      sda_q_r <= {sda_q_r[0], SDA_I};
      scl_d_r <= scl_q_r[1];
      sda_d_r <= sda_q_r[1];
    end
  end
  wire scl_s = scl_q_r[1];
  wire sda_s = sda_q_r[1];
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  logic [3:0] ctrl_r;
  logic [9:0] tar_r;
  logic [9:0] sar_r;
  logic [15:0] hcnt_r;
  logic [15:0] lcnt_r;
  logic [15:0] hold_r;
  logic sel_r;
  logic busy_r;
  logic gcall_r, arb_r, nack_r, hs_r;
  logic [31:0] rdata_r;
  wire wr_ctrl = REG_WR && (REG_ADDR == `OFS_CTRL);
  wire wr_data = REG_WR && (REG_ADDR == `OFS_DATA);
  wire wr_cmdr = REG_WR && (REG_ADDR == `OFS_CMD_RD);
  wire wr_stat = REG_WR && (REG_ADDR == `OFS_STAT);
  wire rd_data = REG_RD && (REG_ADDR == `OFS_DATA);
  wire active = sel_r && ctrl_r[`CTRL_EN];
  wire m_on = active && ctrl_r[`CTRL_MST];
  wire s_on = active && !ctrl_r[`CTRL_MST];
  // status word and read selection
  logic [3:0] tx_lvl, rx_lvl;
  logic [8:0] tx_dout;
  logic [7:0] rx_dout;
  logic m_act;
  wire [31:0] stat_w = {18'h0, hs_r, nack_r, arb_r, gcall_r, m_act,
                        busy_r, rx_lvl, tx_lvl};
  wire [31:0] rd_mux =
    (REG_ADDR == `OFS_CTRL) ? {28'h0, ctrl_r} :
    (REG_ADDR == `OFS_TAR) ? {22'h0, tar_r} :
    (REG_ADDR == `OFS_SAR) ? {22'h0, sar_r} :
    (REG_ADDR == `OFS_DATA) ? {24'h0, rx_dout} :
    (REG_ADDR == `OFS_HCNT) ? {16'h0, hcnt_r} :
    (REG_ADDR == `OFS_LCNT) ? {16'h0, lcnt_r} :
    (REG_ADDR == `OFS_HOLD) ? {16'h0, hold_r} :
    (REG_ADDR == `OFS_STAT) ? stat_w :
    (REG_ADDR == `OFS_SEL) ? {31'h0, sel_r} : 32'h0;
  assign REG_RDATA = rdata_r;
  // software writable state; counts set the bus rate
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_r <= `RST_CTRL;
      tar_r <= 10'h0;
      sar_r <= 10'h0;
      hcnt_r <= `RST_HCNT;
      lcnt_r <= `RST_LCNT;
      hold_r <= `RST_HOLD;
      sel_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= REG_WDATA[3:0];
      if (REG_WR && REG_ADDR == `OFS_TAR) tar_r <= REG_WDATA[9:0];
      if (REG_WR && REG_ADDR == `OFS_SAR) sar_r <= REG_WDATA[9:0];
      if (REG_WR && REG_ADDR == `OFS_HCNT) hcnt_r <= REG_WDATA[15:0];
      if (REG_WR && REG_ADDR == `OFS_LCNT) lcnt_r <= REG_WDATA[15:0];
      if (REG_WR && REG_ADDR == `OFS_HOLD) hold_r <= REG_WDATA[15:0];
      if (REG_WR && REG_ADDR == `OFS_SEL) sel_r <= REG_WDATA[0];
      rdata_r <= REG_RD ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // fifos
  // ----------------------------------------
  logic m_pop, s_pop, m_push, s_push;
  logic [7:0] m_sh_r, s_sh_r;
  wire tx_empty = (tx_lvl == 4'h0);
  wire rx_full = (rx_lvl == `FIFO_DEPTH);
  wire tx_push = wr_data || wr_cmdr;
  wire tx_pop = m_pop || s_pop;
  // entries carry a read tag beside the 8-bit byte
  ctl_fifo #(.W(9)) u_tx (
    .clk(CLK), .rst_n(RST_N), .push(tx_push),
    .din({wr_cmdr, wr_cmdr ? 8'h00 : REG_WDATA[7:0]}),
    .pop(tx_pop), .dout(tx_dout), .level(tx_lvl));
  ctl_fifo #(.W(8)) u_rx (
    .clk(CLK), .rst_n(RST_N), .push(m_push || s_push),
    .din(m_push ? m_sh_r : s_sh_r),
    .pop(rd_data), .dout(rx_dout), .level(rx_lvl));

  // ----------------------------------------
  // master sequencer
  // ----------------------------------------
  i2c_ctl_pkg::mst_t mst_r;
  i2c_ctl_pkg::kind_t kind_r;
  logic m_dir_r, m_scl_low_r, m_sda_low_r;
  logic [3:0] m_bit_r;
  logic [15:0] cnt_r;
  wire is_rd = (kind_r == i2c_ctl_pkg::K_RD);
  wire last_rd = tx_empty || !tx_dout[8];
  wire bit_low = (m_bit_r == 4'h8) ? (is_rd && !last_rd)
                                   : (!is_rd && !m_sh_r[7]);
  wire [7:0] addr_byte = ctrl_r[`CTRL_A10]
    ? {`A10_MARK, tar_r[9:8], tx_dout[8]} : {tar_r[6:0], tx_dout[8]};
  wire m_samp = (mst_r == i2c_ctl_pkg::M_HIGH) && scl_s && (cnt_r == hcnt_r);
  wire m_arb = m_samp && (m_bit_r != 4'h8) && !is_rd && m_sh_r[7] && !sda_s;
  wire m_nack = m_samp && (m_bit_r == 4'h8) && !is_rd && sda_s;
  wire m_done = m_samp && (m_bit_r == 4'h8) && !m_nack;
  wire m_a2 = (kind_r == i2c_ctl_pkg::K_ADDR1) && ctrl_r[`CTRL_A10];
  wire m_turn = !tx_empty && (tx_dout[8] != m_dir_r);
  wire m_next = m_done && !m_a2 && !tx_empty && !m_turn;
  wire m_wait = (mst_r == i2c_ctl_pkg::M_STOP) ||
                (mst_r == i2c_ctl_pkg::M_RSTART);
  assign m_pop = m_next;
  assign m_push = m_done && is_rd && !rx_full;
  assign m_act = (mst_r != i2c_ctl_pkg::M_IDLE);
  // one bit is hold, low count, then high count with stretch wait
  always_ff @(posedge CLK) begin
    if (!RST_N || !m_on) begin
      mst_r <= i2c_ctl_pkg::M_IDLE;
      kind_r <= i2c_ctl_pkg::K_ADDR1;
      {m_dir_r, m_scl_low_r, m_sda_low_r} <= 3'h0;
      m_bit_r <= 4'h0;
      m_sh_r <= 8'h00;
      cnt_r <= 16'h0;
    end else begin
      cnt_r <= (!scl_s && !m_scl_low_r) ? 16'h0 : cnt_r + 16'h1;
      case (mst_r)
        i2c_ctl_pkg::M_IDLE: begin
          cnt_r <= 16'h0;
          if (!tx_empty && !busy_r) begin
            m_dir_r <= tx_dout[8];
            m_sh_r <= addr_byte;
            kind_r <= i2c_ctl_pkg::K_ADDR1;
            m_sda_low_r <= 1'b1;
            mst_r <= i2c_ctl_pkg::M_START;
          end
        end
        i2c_ctl_pkg::M_START: begin
          if (cnt_r == hcnt_r) begin
            m_scl_low_r <= 1'b1;
            cnt_r <= 16'h0;
            m_bit_r <= 4'h0;
            mst_r <= i2c_ctl_pkg::M_LOW;
          end
        end
        i2c_ctl_pkg::M_LOW: begin
          if (cnt_r == hold_r) m_sda_low_r <= bit_low;
          if (cnt_r == lcnt_r) begin
            m_scl_low_r <= 1'b0;
            cnt_r <= 16'h0;
            mst_r <= i2c_ctl_pkg::M_HIGH;
          end
        end
        i2c_ctl_pkg::M_HIGH: begin
          if (m_arb) begin
            {m_scl_low_r, m_sda_low_r} <= 2'h0;
            mst_r <= i2c_ctl_pkg::M_IDLE;
          end else if (m_samp) begin
            m_scl_low_r <= 1'b1;
            cnt_r <= 16'h0;
            m_bit_r <= m_bit_r + 4'h1;
            mst_r <= i2c_ctl_pkg::M_LOW;
            if (m_bit_r != 4'h8) begin
              m_sh_r <= {m_sh_r[6:0], sda_s};
            end else if (m_done && m_a2) begin
              m_sh_r <= tar_r[7:0];
              kind_r <= i2c_ctl_pkg::K_ADDR2;
              m_bit_r <= 4'h0;
            end else if (m_next) begin
              m_sh_r <= tx_dout[7:0];
              kind_r <= tx_dout[8] ? i2c_ctl_pkg::K_RD : i2c_ctl_pkg::K_WR;
              m_bit_r <= 4'h0;
            end else begin
              m_bit_r <= 4'h0;
              mst_r <= (m_done && m_turn && ctrl_r[`CTRL_RSTA])
                ? i2c_ctl_pkg::M_RSTART : i2c_ctl_pkg::M_STOP;
            end
          end
        end
        default: begin
          // stop or restart: low phase, then high phase
          if (m_bit_r == 4'h0) begin
            if (cnt_r == hold_r) m_sda_low_r <= !m_sh_r[0] ||
              (mst_r == i2c_ctl_pkg::M_STOP);
            if (cnt_r == hold_r && mst_r == i2c_ctl_pkg::M_RSTART)
              m_sda_low_r <= 1'b0;
            if (cnt_r == lcnt_r) begin
              m_scl_low_r <= 1'b0;
              cnt_r <= 16'h0;
              m_bit_r <= 4'h1;
            end
          end else if (scl_s && cnt_r == hcnt_r) begin
            cnt_r <= 16'h0;
            if (mst_r == i2c_ctl_pkg::M_STOP) begin
              m_sda_low_r <= 1'b0;
              mst_r <= i2c_ctl_pkg::M_IDLE;
            end else begin
              m_sda_low_r <= 1'b1;
              m_dir_r <= tx_dout[8];
              m_sh_r <= addr_byte;
              kind_r <= i2c_ctl_pkg::K_ADDR1;
              mst_r <= i2c_ctl_pkg::M_START;
            end
          end
          if (!m_wait) mst_r <= i2c_ctl_pkg::M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // slave engine, driven on falling clock
  // ----------------------------------------
  i2c_ctl_pkg::slv_t sst_r;
  logic s_low_r, s_mack_r, s_ten_r;
  logic [3:0] s_bit_r;
  wire s_go = s_on && !stop_det && !start_det;
  wire s_fall = s_go && scl_fall && (sst_r != i2c_ctl_pkg::S_IDLE);
  wire s_adec = s_fall && (sst_r == i2c_ctl_pkg::S_ADDR) && (s_bit_r == 4'h8);
  wire gcall_hit = (s_sh_r == 8'h00);
  wire hs_hit = (s_sh_r[7:3] == `HS_MARK);
  wire rsv_hit = ((s_sh_r[7:4] == 4'h0) && !gcall_hit) ||
    (s_sh_r[7:3] == `RSV_TOP) || (s_sh_r[7:1] == `RSV_A) ||
    (s_sh_r[7:1] == `RSV_B) || (s_sh_r[7:1] == `RSV_C);
  wire m7_hit = !ctrl_r[`CTRL_A10] && (s_sh_r[7:1] == sar_r[6:0]);
  wire m10_hit = ctrl_r[`CTRL_A10] && (s_sh_r[7:3] == `A10_MARK) &&
                 (s_sh_r[2:1] == sar_r[9:8]);
  assign s_push = s_fall && (sst_r == i2c_ctl_pkg::S_RX) &&
                  (s_bit_r == 4'h8) && !rx_full;
  assign s_pop = s_fall && (sst_r == i2c_ctl_pkg::S_TX) &&
                 (s_bit_r == 4'h9) && s_mack_r;
  always_ff @(posedge CLK) begin
    if (!RST_N || !s_on || stop_det) begin
      sst_r <= i2c_ctl_pkg::S_IDLE;
      {s_low_r, s_mack_r, s_ten_r} <= 3'h0;
      s_bit_r <= 4'h0;
      s_sh_r <= 8'h00;
    end else if (start_det) begin
      sst_r <= i2c_ctl_pkg::S_ADDR;
      s_low_r <= 1'b0;
      s_bit_r <= 4'h0;
    end else if (scl_rise && sst_r != i2c_ctl_pkg::S_IDLE) begin
      if (s_bit_r != 4'h8) s_sh_r <= {s_sh_r[6:0], sda_s};
      if (s_bit_r == 4'h8) s_mack_r <= !sda_s;
      s_bit_r <= s_bit_r + 4'h1;
    end else if (s_fall) begin
      s_low_r <= 1'b0;
      if (s_bit_r == 4'h9) begin
        s_bit_r <= 4'h0;
        if (sst_r == i2c_ctl_pkg::S_TX && s_mack_r) begin
          s_sh_r <= tx_empty ? 8'hff : tx_dout[7:0];
          s_low_r <= !tx_empty && !tx_dout[7];
        end else if (sst_r == i2c_ctl_pkg::S_TX) begin
          sst_r <= i2c_ctl_pkg::S_IDLE;
        end
      end else if (s_bit_r != 4'h8) begin
        s_low_r <= (sst_r == i2c_ctl_pkg::S_TX) && !s_sh_r[7];
      end else begin
        case (sst_r)
          i2c_ctl_pkg::S_ADDR: begin
            sst_r <= i2c_ctl_pkg::S_IDLE;
            if (rsv_hit) s_low_r <= 1'b0;
            else if (gcall_hit) begin
              s_low_r <= !rx_full;
              sst_r <= i2c_ctl_pkg::S_RX;
            end else if (m7_hit) begin
              s_low_r <= 1'b1;
              sst_r <= s_sh_r[0] ? i2c_ctl_pkg::S_TX : i2c_ctl_pkg::S_RX;
            end else if (m10_hit && !s_sh_r[0]) begin
              s_low_r <= 1'b1;
              sst_r <= i2c_ctl_pkg::S_ADDR2;
            end else if (m10_hit && s_ten_r) begin
              s_low_r <= 1'b1;
              sst_r <= i2c_ctl_pkg::S_TX;
            end
          end
          i2c_ctl_pkg::S_ADDR2: begin
            s_low_r <= (s_sh_r == sar_r[7:0]);
            s_ten_r <= (s_sh_r == sar_r[7:0]);
            sst_r <= (s_sh_r == sar_r[7:0]) ? i2c_ctl_pkg::S_RX
                                            : i2c_ctl_pkg::S_IDLE;
          end
          i2c_ctl_pkg::S_RX: s_low_r <= !rx_full;
          default: s_low_r <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // bus state, flags and pins
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      busy_r <= 1'b0;
      {gcall_r, arb_r, nack_r, hs_r} <= 4'h0;
    end else begin
      busy_r <= start_det || (busy_r && !stop_det);
      gcall_r <= (s_adec && gcall_hit && !rsv_hit) ||
                 (gcall_r && !(wr_stat && REG_WDATA[`ST_GCALL]));
      arb_r <= m_arb || (arb_r && !(wr_stat && REG_WDATA[`ST_ARB]));
      nack_r <= m_nack || (nack_r && !(wr_stat && REG_WDATA[`ST_NACK]));
      hs_r <= (s_adec && hs_hit) ||
              (hs_r && !(wr_stat && REG_WDATA[`ST_HS]));
    end
  end
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N = !m_scl_low_r;
  assign SDA_OE_N = !(m_sda_low_r || s_low_r);
  assign CTL_SELECT = sel_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_master_start: assert property (@(posedge CLK) disable iff (!RST_N)
    ($rose(m_sda_low_r) && !m_scl_low_r) |-> mst_r == i2c_ctl_pkg::M_START)
    else $error("data fell outside a start");
  a_master_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    ($fell(m_sda_low_r) && !m_scl_low_r && $past(!m_scl_low_r) && m_on)
    |-> mst_r == i2c_ctl_pkg::M_IDLE) else $error("data rose outside a stop");
  a_slave_stable: assert property (@(posedge CLK) disable iff (!RST_N)
    $changed(s_low_r) |-> $past(scl_fall || stop_det || start_det || !s_on))
    else $error("slave data changed with clock high");
  a_addr_byte: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(mst_r == i2c_ctl_pkg::M_START) |-> (m_sh_r[0] == m_dir_r) &&
    (!ctrl_r[`CTRL_A10] || m_sh_r[7:3] == `A10_MARK))
    else $error("address byte malformed");
  a_gcall_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    (s_adec && gcall_hit) |=> gcall_r && sst_r == i2c_ctl_pkg::S_RX)
    else $error("broadcast call not taken");
  a_rsv_ignore: assert property (@(posedge CLK) disable iff (!RST_N)
    (s_adec && rsv_hit) |=> ##1 !s_low_r && sst_r == i2c_ctl_pkg::S_IDLE)
    else $error("reserved address answered");
  a_fifo_cap: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_lvl == `FIFO_DEPTH && !tx_pop) |=> tx_lvl == `FIFO_DEPTH)
    else $error("transmit fifo passed eight entries");
  a_hold_time: assert property (@(posedge CLK) disable iff (!RST_N)
    ($changed(m_sda_low_r) && mst_r == i2c_ctl_pkg::M_LOW)
    |-> $past(cnt_r) == hold_r) else $error("data hold not kept");
  a_stop_empty: assert property (@(posedge CLK) disable iff (!RST_N)
    (m_done && !m_a2 && tx_empty) |=> mst_r == i2c_ctl_pkg::M_STOP)
    else $error("no stop on empty fifo");
  a_read_nack: assert property (@(posedge CLK) disable iff (!RST_N)
    (mst_r == i2c_ctl_pkg::M_HIGH && is_rd && m_bit_r == 4'h8 && tx_empty)
    |-> !m_sda_low_r) else $error("last read byte acknowledged");
  a_arb_release: assert property (@(posedge CLK) disable iff (!RST_N)
    m_arb |=> !m_scl_low_r && !m_sda_low_r && arb_r)
    else $error("bus held after lost arbitration");
  a_sel_route: assert property (@(posedge CLK) disable iff (!RST_N)
    !sel_r |=> SCL_OE_N && SDA_OE_N) else $error("bus driven while routed away");
endmodule : i2c_fifo_ctl
`default_nettype wire

//--- dv/i2c_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
// far side of the two-wire bus: a target at ADDR and a slow master
module i2c_bus_partner #(parameter logic [6:0] ADDR = 7'h55) (
  // bus wires as seen
  input wire logic scl,
  input wire logic sda,
  // pull requests
  output logic scl_low,
  output logic sda_low
);
  logic s_low = 1'b0;
  logic m_low = 1'b0;
  logic ph = 1'b0;
  logic rd = 1'b0;
  logic match = 1'b0;
  logic tx = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] txb = 8'h00;
  int nbit = 0;
  int starts = 0;
  int stops = 0;
  logic [7:0] got[$];
  logic [7:0] txq[$];
  logic macks[$];
  assign sda_low = s_low | m_low;
  initial scl_low = 1'b0;
  // start: data falls with clock high
  always @(negedge sda) if (scl === 1'b1 && $time > 0) begin // not settling
    starts++;
    nbit = 0;
    ph = 1'b0;
    tx = 1'b0;
  end
  // stop: data rises with clock high
  always @(posedge sda) if (scl === 1'b1 && $time > 0) stops++;
  // sample on rising clock
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    nbit++;
  end
  // change data only while clock is low
  always @(negedge scl) begin
    s_low = 1'b0;
    if (nbit == 8) begin
      got.push_back(sh);
      if (!ph) begin
        match = (sh[7:1] == ADDR);
        rd = sh[0];
        ph = 1'b1;
      end
      s_low = match && !tx;
    end else if (nbit == 9) begin
      nbit = 0;
      if (tx) macks.push_back(sh[0]);
      tx = match && rd && !sh[0];
      if (tx) txb = txq.pop_front();
    end
    if (tx && nbit < 8) s_low = !txb[7 - nbit];
  end
  // master side, 80 ns bit period
  task automatic m_start();
    m_low = 1'b1;
    #40 scl_low = 1'b1;
    #20;
  endtask : m_start
  task automatic m_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      m_low = (i >= 0) ? !b[i] : 1'b0;
      #20 scl_low = 1'b0;
      #40 ack = sda;
      scl_low = 1'b1;
      #20;
    end
  endtask : m_byte
  task automatic m_stop();
    m_low = 1'b1;
    #20 scl_low = 1'b0;
    #20 m_low = 1'b0;
    #40;
  endtask : m_stop
endmodule : i2c_bus_partner
`default_nettype wire

//--- dv/i2c_fifo_ctl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ctl_consts.svh"
module i2c_fifo_ctl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, v;
  logic scl_oe_n, sda_oe_n, ctl_select, p_scl, p_sda, ack;
  logic [7:0] d0, d1, d2, d3, r0, r1;
  logic [7:0] exp[$];
  logic [7:0] rsv[5] = '{8'h03, 8'h08, 8'hf8, 8'h18, 8'hc2};
  int bad_count = 0;
  int n_tests = 0;
  // open-drain wires with pull-up
  wire scl = !(scl_oe_n === 1'b0 || p_scl);
  wire sda = !(sda_oe_n === 1'b0 || p_sda);
  i2c_fifo_ctl i2c_fifo_ctl_i (.CLK(clk), .RST_N(rst_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SCL_I(scl), .SCL_O(),
    .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(), .SDA_OE_N(sda_oe_n),
    .CTL_SELECT(ctl_select));
  i2c_bus_partner peer (.scl(scl), .sda(sda), .scl_low(p_scl),
    .sda_low(p_sda));
  // 250 MHz clock
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic wait_stops(input int n);
    for (int i = 0; i < 40000 && peer.stops < n; i++) @(posedge clk);
    if (peer.stops < n) begin
      bad_count++;
      $display("ERROR %0t: no stop seen on the bus", $time);
    end
    repeat (20) @(posedge clk);
  endtask : wait_stops
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // watchdog against a hung bus
  initial begin
    #300000;
    bad_count++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h4e67acf5));
    {d0, d1, d2, d3, r0, r1} = 48'({$urandom, $urandom});
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFS_SEL, v);
    chk(v, 32'h0);
    chk(32'(ctl_select), 32'h0);
    rd(`OFS_HCNT, v);
    chk(v, 32'(`RST_HCNT));
    rd(9'h0fc, v);
    chk(v, 32'h0);
    wr(`OFS_SEL, 32'h1);
    @(posedge clk);
    chk(32'(ctl_select), 32'h1);
    $display("registers test done");
    wr(`OFS_HCNT, 32'h8);
    wr(`OFS_LCNT, 32'h8);
    wr(`OFS_HOLD, 32'h2);
    wr(`OFS_TAR, 32'h55);
    wr(`OFS_DATA, 32'(d0));
    wr(`OFS_DATA, 32'(d1));
    wr(`OFS_CTRL, 32'h3);
    exp = '{8'haa, d0, d1};
    wait_stops(1);
    chk(32'(peer.starts), 32'h1);
    chk(32'(peer.stops), 32'h1);
    $display("master write test done");
    peer.txq = '{r0, r1};
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_DATA, 32'(d2));
    wr(`OFS_CMD_RD, 32'h0);
    wr(`OFS_CMD_RD, 32'h0);
    wr(`OFS_CTRL, 32'h7);
    exp = {exp, 8'haa, d2, 8'hab, r0, r1};
    wait_stops(2);
    chk(32'(peer.starts), 32'h3);
    chk(32'(peer.macks.size()), 32'h2);
    chk(32'({peer.macks[0], peer.macks[1]}), 32'h1);
    rd(`OFS_DATA, v);
    chk(v[7:0], 32'(r0));
    rd(`OFS_DATA, v);
    chk(v[7:0], 32'(r1));
    $display("master read test done");
    // direction change without restart: stop, then a fresh start
    peer.txq = '{d3};
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_DATA, 32'(d0));
    wr(`OFS_CMD_RD, 32'h0);
    wr(`OFS_CTRL, 32'h3);
    exp = {exp, 8'haa, d0, 8'hab, d3};
    wait_stops(4);
    chk(32'(peer.starts), 32'h5);
    chk(32'(peer.stops), 32'h4);
    chk(32'(peer.macks.size()), 32'h3);
    chk(32'(peer.macks[2]), 32'h1);
    rd(`OFS_DATA, v);
    chk(v[7:0], 32'(d3));
    $display("stop then start test done");
    wr(`OFS_CTRL, 32'h1);
    peer.m_start();
    peer.m_byte(8'h00, ack);
    chk(32'(ack), 32'h0);
    peer.m_byte(d3, ack);
    chk(32'(ack), 32'h0);
    peer.m_stop();
    exp = {exp, 8'h00, d3};
    rd(`OFS_STAT, v);
    chk(32'(v[10]), 32'h1);
    rd(`OFS_DATA, v);
    chk(v[7:0], 32'(d3));
    foreach (rsv[i]) begin
      peer.m_start();
      peer.m_byte(rsv[i], ack);
      chk(32'(ack), 32'h1);
      peer.m_stop();
      exp.push_back(rsv[i]);
    end
    // broadcast and high-speed flags, then write-one clear
    rd(`OFS_STAT, v);
    chk(32'(v[13:10]), 32'h9);
    wr(`OFS_STAT, 32'h2400);
    rd(`OFS_STAT, v);
    chk(32'(v[13:10]), 32'h0);
    // 10-bit slave write: marker byte, low address byte, data
    wr(`OFS_SAR, 32'h1a7);
    wr(`OFS_CTRL, 32'h9);
    peer.m_start();
    peer.m_byte(8'hf2, ack);
    chk(32'(ack), 32'h0);
    peer.m_byte(8'ha7, ack);
    chk(32'(ack), 32'h0);
    peer.m_byte(d1, ack);
    chk(32'(ack), 32'h0);
    peer.m_stop();
    exp = {exp, 8'hf2, 8'ha7, d1};
    rd(`OFS_DATA, v);
    chk(v[7:0], 32'(d1));
    $display("slave test done");
    chk(32'(peer.got.size()), 32'(exp.size()));
    foreach (exp[i]) chk(32'(peer.got[i]), 32'(exp[i]));
    stop_test();
  end
endmodule : i2c_fifo_ctl_tb
`default_nettype wire
